// file: inc/clu_pkg.sv
/*
 * Constants shared by both ends of the character display instruction link:
 * instruction fields, address limits, timing counts and the register map of
 * the host controller.
 * Assumes a single 25 MHz clock on both ends.
 */
package clu_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_NS       = 40;
	localparam int CMD_BUSY_NS  = 37000;
	localparam int DATA_BUSY_NS = 43000;
	localparam int STB_SETUP_NS = 40;
	localparam int STB_PW_NS    = 230;
	localparam int STB_CYCLE_NS = 500;
	localparam int BUSY_W       = 11;
	localparam int STB_W        = 4;
	// Busy times are nominal, so they round down; strobe times are minima.
	localparam logic [BUSY_W-1:0] CMD_BUSY_CYC  = BUSY_W'(CMD_BUSY_NS / CLK_NS);
	localparam logic [BUSY_W-1:0] DATA_BUSY_CYC = BUSY_W'(DATA_BUSY_NS / CLK_NS);
	localparam int SETUP_I = (STB_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PW_I    = (STB_PW_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYCLE_I = (STB_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [STB_W-1:0] SETUP_CYC = STB_W'(SETUP_I);
	localparam logic [STB_W-1:0] PW_CYC    = STB_W'(PW_I);
	localparam logic [STB_W-1:0] REC_CYC   = STB_W'(CYCLE_I - PW_I - SETUP_I);

	// ------------------------------------------------------------------
	// Instruction fields and address limits
	// ------------------------------------------------------------------
	localparam int FS_WIDTH_BIT = 4;
	localparam int FS_LINES_BIT = 3;
	localparam int FS_FONT_BIT  = 2;
	localparam logic [6:0] ADDR_FIRST    = 7'h00;
	localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
	localparam logic [6:0] LINE1_LAST    = 7'h27;
	localparam logic [6:0] LINE2_FIRST   = 7'h40;
	localparam logic [6:0] LINE2_LAST    = 7'h67;
	localparam logic       RST_WIDE      = 1'b1;

	// ------------------------------------------------------------------
	// Host controller register map
	// ------------------------------------------------------------------
	localparam logic [3:0] CMD_OFF  = 4'h0;
	localparam logic [3:0] STAT_OFF = 4'h4;
	localparam logic [3:0] CTRL_OFF = 4'h8;
	localparam int CMD_RS_BIT   = 8;
	localparam int CMD_RW_BIT   = 9;
	localparam int CTRL_NARROW  = 0;
	localparam int CTRL_POLL    = 1;
	localparam logic RST_POLL   = 1'b1;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_HIGH, HS_LOW}
		clu_host_state_type;

endpackage : clu_pkg

// file: inc/clu_bus_if.sv
/*
 * Parallel instruction bus between host controller and display device.
 * The shared data lines are resolved here from the two output enables;
 * an undriven bus reads as all ones, as a pull-up would give.
 */
`timescale 1ns/1ns
`default_nettype none

interface clu_bus_if;
	logic       reg_select;
	logic       rw;
	logic       strobe;
	logic [7:0] host_db;
	logic       host_db_oe_n;
	logic [7:0] dev_db;
	logic       dev_db_oe_n;
	logic [7:0] db;

	// Wire level of the shared data lines.
	assign db = !host_db_oe_n ? host_db :
		(!dev_db_oe_n ? dev_db : 8'hff);

	modport host (output reg_select, rw, strobe, host_db, host_db_oe_n,
		input db);
	modport device (input reg_select, rw, strobe, db,
		output dev_db, dev_db_oe_n);
endinterface : clu_bus_if

`default_nettype wire

// file: core/clu_device.sv
/*
 * Instruction interpreter of the character display: configuration,
 * address set, busy/address read and RAM data access with auto stepping.
 * Assumes bus inputs are synchronous to aclk and the strobe is held high
 * for at least two clock cycles.
 */
// Summary of operation
// - Width bit high: 8-bit, low: 4-bit
// - Narrow mode: two nibble transfers on upper lines
// - Lines bit: low one line, high two
// - Font bit: low 5x8, high 5x11
// - 01 prefix: load six bits, glyph RAM
// - 1 prefix: load seven bits, display RAM
// - One line: addresses 00 to 4F
// - Two lines: 00-27 and 40-67
// - Status read: busy top, counter below
// - Host waits while busy reads high
// - Data write stores into selected RAM
// - Counter steps after each RAM write
// - Data read returns byte, then steps
// - Address set prefetches byte for read
// - Host sets address or discards first read
// - Read after write returns latched data
// - No display shift after glyph read
// - Config/address set busy about 37 us
// - Data access busy about 43 us
// - Step direction bit: up or down
`timescale 1ns/1ns
`default_nettype none

module clu_device
	import clu_pkg::*;
#(
	parameter int DISP_DEPTH  = 128,
	parameter int GLYPH_DEPTH = 64
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Instruction bus
	clu_bus_if.device       bus,
	// Entry-mode direction from the rest of the controller
	input  wire logic       step_up,
	// Display refresh read port
	input  wire logic [6:0] refresh_addr,
	output var  logic [7:0] refresh_data,
	// Configuration and state
	output var  logic       bus_width_sel,
	output var  logic       two_line,
	output var  logic       font_tall,
	output var  logic       glyph_sel,
	output var  logic       busy_flag,
	output var  logic [6:0] addr_counter
);

	// ------------------------------------------------------------------
	// Storage and internal state
	// ------------------------------------------------------------------
	logic [7:0]        disp_mem [DISP_DEPTH];
	logic [7:0]        glyph_mem [GLYPH_DEPTH];
	logic              strobe_d;
	logic              lat_rs;
	logic              lat_rw;
	logic [7:0]        lat_db;
	logic              nib;
	logic [3:0]        upper;
	logic [7:0]        out_reg;
	logic              prefetch;
	logic [BUSY_W-1:0] busy_cnt;
	logic              fall;
	logic              rise;
	logic              full;
	logic [7:0]        byte_in;
	logic              is_cmd;
	logic              addr_set;
	logic              cfg_set;
	logic              wr_data;
	logic              rd_data;
	logic [7:0]        rd_byte;

	// Next address after a data access, wrapping inside the valid range.
	function automatic logic [6:0] step_addr(input logic [6:0] a,
		input logic up, input logic glyph, input logic two);
		logic [5:0] g;
		g = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
		if (glyph) begin
			step_addr = {1'b0, g};
		end else if (two) begin
			if (up) begin
				step_addr = (a == LINE1_LAST) ? LINE2_FIRST :
					((a == LINE2_LAST) ? ADDR_FIRST : a + 7'h01);
			end else begin
				step_addr = (a == LINE2_FIRST) ? LINE1_LAST :
					((a == ADDR_FIRST) ? LINE2_LAST : a - 7'h01);
			end
		end else if (up) begin
			step_addr = (a == ONE_LINE_LAST) ? ADDR_FIRST : a + 7'h01;
		end else begin
			step_addr = (a == ADDR_FIRST) ? ONE_LINE_LAST : a - 7'h01;
		end
	endfunction : step_addr

	// ------------------------------------------------------------------
	// Strobe edges and transfer capture
	// ------------------------------------------------------------------
	// Bus lines are latched while the strobe is high, so the values used
	// at the falling edge are those that stood before it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strobe_d <= 1'b0;
			lat_rs   <= 1'b0;
			lat_rw   <= 1'b0;
			lat_db   <= 8'h00;
		end else begin
			strobe_d <= bus.strobe;
			if (bus.strobe) begin
				lat_rs <= bus.reg_select;
				lat_rw <= bus.rw;
				lat_db <= bus.db;
			end
		end
	end

	// Edge detection and decode of a completed byte transfer.
	assign fall     = strobe_d & ~bus.strobe;
	assign rise     = ~strobe_d & bus.strobe;
	assign full     = fall & (bus_width_sel | nib);
	assign byte_in  = bus_width_sel ? lat_db : {upper, lat_db[7:4]};
	assign is_cmd   = full & ~lat_rs & ~lat_rw & ~busy_flag;
	assign addr_set = is_cmd & (byte_in[7] | (byte_in[7:6] == 2'b01));
	assign cfg_set  = is_cmd & (byte_in[7:5] == 3'b001);
	assign wr_data  = full & lat_rs & ~lat_rw & ~busy_flag;
	assign rd_data  = full & lat_rs & lat_rw & ~busy_flag;
	assign rd_byte  = bus.reg_select ? out_reg
		: {busy_flag, addr_counter};

	// Nibble pairing: the first transfer holds the upper half.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nib   <= 1'b0;
			upper <= 4'h0;
		end else if (bus_width_sel) begin
			nib <= 1'b0;
		end else if (fall) begin
			nib <= ~nib;
			if (!nib) begin
				upper <= lat_db[7:4];
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration
	// ------------------------------------------------------------------
	// A width change takes effect after the instruction that carries it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_width_sel <= RST_WIDE;
			two_line      <= 1'b0;
			font_tall     <= 1'b0;
		end else if (cfg_set) begin
			bus_width_sel <= byte_in[FS_WIDTH_BIT];
			two_line      <= byte_in[FS_LINES_BIT];
			font_tall     <= byte_in[FS_FONT_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Address counter and RAM selection
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_counter <= ADDR_FIRST;
			glyph_sel    <= 1'b0;
		end else if (addr_set) begin
			if (byte_in[7]) begin
				addr_counter <= byte_in[6:0];
				glyph_sel    <= 1'b0;
			end else begin
				addr_counter <= {1'b0, byte_in[5:0]};
				glyph_sel    <= 1'b1;
			end
		end else if (wr_data | rd_data) begin
			addr_counter <= step_addr(addr_counter, step_up,
				glyph_sel, two_line);
		end
	end

	// ------------------------------------------------------------------
	// RAM write and read prefetch
	// ------------------------------------------------------------------
	// Writes never touch the output register, so a read that follows a
	// write still returns what was fetched earlier.
	always_ff @(posedge aclk) begin
		if (wr_data) begin
			if (glyph_sel) begin
				glyph_mem[addr_counter[5:0]] <= byte_in;
			end else begin
				disp_mem[addr_counter] <= byte_in;
			end
		end
	end

	// The fetch runs one cycle after the counter has moved.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prefetch <= 1'b0;
			out_reg  <= 8'h00;
		end else begin
			prefetch <= addr_set | rd_data;
			if (prefetch) begin
				out_reg <= glyph_sel ? glyph_mem[addr_counter[5:0]]
					: disp_mem[addr_counter];
			end
		end
	end

	// Refresh port for the display scan logic.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refresh_data <= 8'h00;
		end else begin
			refresh_data <= disp_mem[refresh_addr];
		end
	end

	// ------------------------------------------------------------------
	// Busy timer
	// ------------------------------------------------------------------
	// While busy, instructions and data accesses are not acted on; a read of
	// either register still drives the lines, a data read with out_reg.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_flag <= 1'b0;
			busy_cnt  <= '0;
		end else if (is_cmd) begin
			busy_flag <= 1'b1;
			busy_cnt  <= CMD_BUSY_CYC;
		end else if (wr_data | rd_data) begin
			busy_flag <= 1'b1;
			busy_cnt  <= DATA_BUSY_CYC;
		end else if (busy_flag) begin
			busy_cnt <= busy_cnt - BUSY_W'(1);
			if (busy_cnt == BUSY_W'(1)) begin
				busy_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Read data drive
	// ------------------------------------------------------------------
	// Data lines are driven from the cycle after the rising strobe until
	// the falling strobe is seen.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus.dev_db      <= 8'h00;
			bus.dev_db_oe_n <= 1'b1;
		end else if (rise & bus.rw) begin
			bus.dev_db_oe_n <= 1'b0;
			if (bus_width_sel) begin
				bus.dev_db <= rd_byte;
			end else if (nib) begin
				bus.dev_db <= {rd_byte[3:0], 4'h0};
			end else begin
				bus.dev_db <= {rd_byte[7:4], 4'h0};
			end
		end else if (fall) begin
			bus.dev_db_oe_n <= 1'b1;
		end
	end

endmodule : clu_device

`default_nettype wire

// file: core/clu_host.sv
/*
 * Host controller for the display instruction bus, commanded by software
 * over an AXI4-Lite slave. Each command is one byte transfer, split into
 * two nibble transfers in narrow mode, optionally preceded by busy polling.
 * Assumes the device end samples the bus on the same aclk.
 */
`timescale 1ns/1ns
`default_nettype none

module clu_host
	import clu_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Instruction bus
	clu_bus_if.host                bus,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	clu_host_state_type state;
	logic [ADDR_W-1:0]  aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               aw_held;
	logic               w_held;
	logic               wr_go;
	logic               start;
	logic               narrow;
	logic               auto_poll;
	logic               pending;
	logic               polling;
	logic               cmd_rs;
	logic               cmd_rw;
	logic [7:0]         cmd_byte;
	logic [7:0]         asm_byte;
	logic [7:0]         rd_byte;
	logic               nib;
	logic [STB_W-1:0]   cnt;
	logic               cur_rs;
	logic               cur_rw;

	// Both halves of a write are in and no response is outstanding.
	assign wr_go  = aw_held & w_held & ~s_axi_bvalid;
	assign start  = wr_go & (aw_addr == CMD_OFF) & (w_strb[1:0] == 2'b11)
		& ~pending;
	assign cur_rs = polling ? 1'b0 : cmd_rs;
	assign cur_rw = polling ? 1'b1 : cmd_rw;

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	// Address and data are taken in either order; the response follows
	// the cycle after both are held.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == CMD_OFF || aw_addr == STAT_OFF
					|| aw_addr == CTRL_OFF) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Control register: bus width seen by the host and busy polling.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			narrow    <= ~RST_WIDE;
			auto_poll <= RST_POLL;
		end else if (wr_go && aw_addr == CTRL_OFF && w_strb[0]) begin
			narrow    <= w_data[CTRL_NARROW];
			auto_poll <= w_data[CTRL_POLL];
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case (s_axi_araddr)
				CMD_OFF:  s_axi_rdata <= {22'h0, cmd_rw, cmd_rs, cmd_byte};
				STAT_OFF: s_axi_rdata <= {16'h0, rd_byte, 6'h0, polling,
					pending};
				CTRL_OFF: s_axi_rdata <= {30'h0, auto_poll, narrow};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Bus transfer engine
	// ------------------------------------------------------------------
	// With polling on, a status read is repeated until busy reads low
	// before the command goes out; with it off, software must poll.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state            <= HS_IDLE;
			cnt              <= '0;
			nib              <= 1'b0;
			pending          <= 1'b0;
			polling          <= 1'b0;
			cmd_rs           <= 1'b0;
			cmd_rw           <= 1'b0;
			cmd_byte         <= 8'h00;
			asm_byte         <= 8'h00;
			rd_byte          <= 8'h00;
			bus.reg_select   <= 1'b0;
			bus.rw           <= 1'b0;
			bus.strobe       <= 1'b0;
			bus.host_db      <= 8'h00;
			bus.host_db_oe_n <= 1'b1;
		end else begin
			case (state)
				HS_IDLE: begin
					if (start) begin
						cmd_byte <= w_data[7:0];
						cmd_rs   <= w_data[CMD_RS_BIT];
						cmd_rw   <= w_data[CMD_RW_BIT];
						pending  <= 1'b1;
						polling  <= auto_poll;
					end else if (pending) begin
						bus.reg_select   <= cur_rs;
						bus.rw           <= cur_rw;
						bus.host_db_oe_n <= cur_rw;
						bus.host_db      <= narrow ? {cmd_byte[7:4], 4'h0}
							: cmd_byte;
						cnt   <= SETUP_CYC;
						state <= HS_SETUP;
					end
				end
				HS_SETUP: begin
					cnt <= cnt - STB_W'(1);
					if (cnt == STB_W'(1)) begin
						bus.strobe <= 1'b1;
						cnt        <= PW_CYC;
						state      <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					cnt <= cnt - STB_W'(1);
					if (cnt == STB_W'(1)) begin
						bus.strobe <= 1'b0;
						cnt        <= REC_CYC;
						state      <= HS_LOW;
						if (!narrow) begin
							asm_byte <= bus.db;
						end else if (nib) begin
							asm_byte[3:0] <= bus.db[7:4];
						end else begin
							asm_byte[7:4] <= bus.db[7:4];
						end
					end
				end
				HS_LOW: begin
					cnt <= cnt - STB_W'(1);
					if (cnt == STB_W'(1)) begin
						if (narrow && !nib) begin
							nib         <= 1'b1;
							bus.host_db <= {cmd_byte[3:0], 4'h0};
							cnt         <= SETUP_CYC;
							state       <= HS_SETUP;
						end else begin
							nib              <= 1'b0;
							bus.host_db_oe_n <= 1'b1;
							state            <= HS_IDLE;
							if (polling) begin
								polling <= asm_byte[7];
							end else begin
								pending <= 1'b0;
								if (cmd_rw) begin
									rd_byte <= asm_byte;
								end
							end
						end
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end

endmodule : clu_host

`default_nettype wire

// file: testbench/clu_link_props.sv
/* Assertions on the display instruction link.
   Assumes it sees the interface wires and the device state. */
`timescale 1ns/1ns
`default_nettype none

module clu_link_props (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Link wires
	input wire logic       reg_select,
	input wire logic       rw,
	input wire logic       strobe,
	input wire logic       host_db_oe_n,
	input wire logic       dev_db_oe_n,
	input wire logic [7:0] db,
	// Device state
	input wire logic       busy_flag,
	input wire logic       bus_width_sel,
	input wire logic       glyph_sel,
	input wire logic [6:0] addr_counter
);
	// ----------------
	// Helpers
	// ----------------
	logic [10:0] busy_len;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Busy periods are far too long for a repetition, so count them.
	always_ff @(posedge aclk) begin
		if (!aresetn || !busy_flag) begin
			busy_len <= 11'h0;
		end else begin
			busy_len <= busy_len + 11'h1;
		end
	end

	// A whole byte acted on in wide mode while the device is idle.
	sequence acted;
		$fell(strobe) && !busy_flag && bus_width_sel;
	endsequence
	sequence instr;
		acted ##0 (!rw && !reg_select);
	endsequence

	// ----------------
	// Properties
	// ----------------
	one_driver_a: assert property (
		host_db_oe_n || dev_db_oe_n)
		else $error("both ends drive the data lines");
	strobe_high_a: assert property (
		$rose(strobe) |-> strobe[*6] ##1 !strobe)
		else $error("strobe high time wrong");
	strobe_low_a: assert property (
		$fell(strobe) |-> !strobe[*6])
		else $error("strobe low time wrong");
	dev_drive_a: assert property (
		$rose(strobe) && rw && !reg_select |-> ##[1:2] !dev_db_oe_n)
		else $error("device did not answer a read");
	read_only_a: assert property (
		!dev_db_oe_n |-> rw)
		else $error("device drove during a write");
	status_addr_a: assert property (
		$fell(strobe) && rw && !reg_select && bus_width_sel
		|-> $past(db[6:0]) == addr_counter)
		else $error("status read lost the counter");
	disp_addr_a: assert property (
		instr ##0 db[7] |-> ##[1:2] (addr_counter == db[6:0] && !glyph_sel))
		else $error("display address not loaded");
	glyph_addr_a: assert property (
		instr ##0 (db[7:6] == 2'b01)
		|-> ##[1:2] (addr_counter[5:0] == db[5:0] && glyph_sel))
		else $error("glyph address not loaded");
	width_set_a: assert property (
		instr ##0 (db[7:5] == 3'b001) |-> ##[1:2] bus_width_sel == db[4])
		else $error("width bit not taken");
	busy_start_a: assert property (
		acted ##0 !(rw && !reg_select) |-> ##[1:2] busy_flag)
		else $error("busy not raised");
	busy_len_a: assert property (
		$fell(busy_flag) |-> busy_len inside {[924:926], [1074:1076]})
		else $error("busy period of wrong length");
endmodule : clu_link_props

`default_nettype wire

// file: testbench/tb_char_lcd_instruction_unit.sv
/* Bench for the display link: host driven over AXI4-Lite, device on
   the far end, checker on the wires. Assumes one 25 MHz clock. */
`timescale 1ns/1ns
`default_nettype none

module tb_char_lcd_instruction_unit
	import clu_pkg::*;
;
	// ----------------
	// Signals
	// ----------------
	logic        aclk, aresetn, step_up;
	logic [6:0]  refresh_addr, addr_counter;
	logic [7:0]  refresh_data;
	logic        bus_width_sel, two_line, font_tall, glyph_sel, busy_flag;
	logic [3:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, res;
	logic [1:0]  bresp, rresp;
	int          n_errors, compares;

	clu_bus_if bus ();

	clu_host i_clu_host (.aclk(aclk), .aresetn(aresetn), .bus(bus),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	clu_device i_clu_device (.aclk(aclk), .aresetn(aresetn), .bus(bus),
		.step_up(step_up), .refresh_addr(refresh_addr),
		.refresh_data(refresh_data), .bus_width_sel(bus_width_sel),
		.two_line(two_line), .font_tall(font_tall), .glyph_sel(glyph_sel),
		.busy_flag(busy_flag), .addr_counter(addr_counter));

	clu_link_props i_clu_link_props (.aclk(aclk), .aresetn(aresetn),
		.reg_select(bus.reg_select), .rw(bus.rw), .strobe(bus.strobe),
		.host_db_oe_n(bus.host_db_oe_n), .dev_db_oe_n(bus.dev_db_oe_n),
		.db(bus.db), .busy_flag(busy_flag), .bus_width_sel(bus_width_sel),
		.glyph_sel(glyph_sel), .addr_counter(addr_counter));

	// Free-running clock, 40 ns period.
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ----------------
	// Tasks
	// ----------------
	task summarize();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	task hang();
		n_errors++;
		summarize();
	endtask : hang

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Write with both channels offered together, held until taken.
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 50) hang();
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr

	task rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		d = rdata;
		if (n == 50) hang();
		chk("rresp", 32'h0, {30'h0, rresp});
	endtask : rd

	// One link transfer; optionally waits out the device busy time.
	task op(input logic [9:0] c, input logic wb);
		int n;
		wr(CMD_OFF, {22'h0, c}, RESP_OKAY);
		for (n = 0; n < 500; n++) begin
			rd(STAT_OFF, res);
			if (res[0] === 1'b0) break;
		end
		if (n == 500) hang();
		for (n = 0; wb && n < 1200; n++) begin
			@(posedge aclk);
			if (busy_flag === 1'b0) break;
		end
		if (n == 1200) hang();
		rd(STAT_OFF, res);
	endtask : op

	// ----------------
	// Sequence
	// ----------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = 40'h0;
		step_up = 1'b1;
		refresh_addr = 7'h26;
		n_errors = 0;
		compares = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk("width", 32'h1, {31'h0, bus_width_sel});
		wr(CTRL_OFF, 32'h0, RESP_OKAY);
		wr(4'hc, 32'h0, RESP_SLVERR);
		op(10'h03c, 1'b1);
		chk("cfg", 32'h7, {29'h0, two_line, font_tall, bus_width_sel});
		op(10'h0a6, 1'b1);
		op(10'h141, 1'b1);
		op(10'h142, 1'b1);
		op(10'h143, 1'b1);
		chk("counter", 32'h41, {25'h0, addr_counter});
		op(10'h200, 1'b1);
		chk("status", 32'h41, {24'h0, res[15:8]});
		chk("refresh", 32'h41, {24'h0, refresh_data});
		op(10'h0a6, 1'b1);
		op(10'h300, 1'b1);
		chk("read a", 32'h41, {24'h0, res[15:8]});
		op(10'h300, 1'b1);
		chk("read b", 32'h42, {24'h0, res[15:8]});
		chk("counter", 32'h40, {25'h0, addr_counter});
		step_up <= 1'b0;
		op(10'h0c0, 1'b1);
		op(10'h300, 1'b1);
		chk("read c", 32'h43, {24'h0, res[15:8]});
		chk("counter", 32'h27, {25'h0, addr_counter});
		step_up <= 1'b1;
		// A write moves the counter but leaves the fetched byte in place.
		op(10'h144, 1'b1);
		op(10'h300, 1'b1);
		chk("stale", 32'h42, {24'h0, res[15:8]});
		op(10'h045, 1'b1);
		op(10'h11f, 1'b1);
		op(10'h045, 1'b1);
		op(10'h300, 1'b1);
		chk("glyph", 32'h1f, {24'h0, res[15:8]});
		op(10'h030, 1'b1);
		op(10'h0cf, 1'b1);
		op(10'h155, 1'b1);
		chk("counter", 32'h0, {25'h0, addr_counter});
		op(10'h090, 1'b0);
		op(10'h177, 1'b1);
		chk("refused", 32'h10, {25'h0, addr_counter});
		op(10'h020, 1'b1);
		chk("width", 32'h0, {31'h0, bus_width_sel});
		// Narrow mode with host polling: back-to-back requests must wait.
		wr(CTRL_OFF, 32'h3, RESP_OKAY);
		refresh_addr <= 7'h05;
		rd(CTRL_OFF, res);
		chk("ctrl", 32'h3, res);
		op(10'h085, 1'b0);
		chk("counter", 32'h05, {25'h0, addr_counter});
		op(10'h15a, 1'b0);
		op(10'h200, 1'b1);
		chk("status", 32'h06, {24'h0, res[15:8]});
		chk("refresh", 32'h5a, {24'h0, refresh_data});
		summarize();
	end
endmodule : tb_char_lcd_instruction_unit

`default_nettype wire
